// ==== src/rwcc_pkg.sv ====
// Purpose: Shared constants for the reset, wake and clock control block.
// Assumes: 125 MHz system clock, AXI4-Lite register access.
// Notes:   Offsets are byte addresses.
`default_nettype none
package rwcc_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_WAKE_LEVEL = 8'h00;
  localparam logic [7:0] OFS_WAKE_EN    = 8'h04;
  localparam logic [7:0] OFS_XTAL_CTRL  = 8'h08;
  localparam logic [7:0] OFS_CLK_EN     = 8'h10;
  localparam logic [7:0] OFS_SYS_CAUSE  = 8'h14;
  localparam logic [7:0] OFS_RAD_CAUSE  = 8'h18;
  localparam logic [7:0] OFS_PWR_CTRL   = 8'h1c;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [4:0]  WAKE_LEVEL_RST = 5'h00;
  localparam logic [4:0]  WAKE_EN_RST    = 5'h07;
  localparam logic        XTAL_SEL_RST   = 1'h0;
  localparam logic [15:0] CLK_EN_RST     = 16'h7fff;
  localparam logic [10:0] RAD_CAUSE_RST  = 11'h004;
  localparam logic        BOR_EN_RST     = 1'h1;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CK_DMA = 0;
  localparam int unsigned CK_RADIO_CTRL = 1;
  localparam int unsigned CK_RADIO_GEN = 2;
  localparam int unsigned CK_SPI = 8;
  localparam int unsigned SC_SYSREQ = 1;
  localparam int unsigned SC_WDG = 2;
  localparam int unsigned SC_LOCKUP = 3;
  localparam int unsigned RC_BOR = 1;
  localparam int unsigned RC_POR = 2;
  localparam int unsigned RC_PIN0 = 3;
  localparam int unsigned RC_TMR1 = 8;
  localparam int unsigned RC_TMR2 = 10;
  localparam int unsigned PC_BOR_EN = 0;
  localparam int unsigned PC_SRC_XTAL = 1;
  localparam int unsigned PC_SLEEP = 2;
  localparam int unsigned PC_STANDBY = 3;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned CORE_RST_NS = 64;
  localparam int unsigned CORE_RST_CYC = (CORE_RST_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0]  CORE_RST_CNT = 4'(CORE_RST_CYC);
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {PS_RUN, PS_SLEEP, PS_STANDBY} rwcc_pwr_e;
endpackage : rwcc_pkg
`default_nettype wire

// ==== src/rwcc_reset_wake_clock_control.sv ====
// Purpose: Power-on, wake and system reset generation, cause records, clock gating.
// Assumes: Pins and analog flags are asynchronous; core signals share clk.
// Notes:   Registers are reached over AXI4-Lite, one word each.
//
// The AXI4-Lite register port is this design's own decision.
`default_nettype none
module rwcc_reset_wake_clock_control
  import rwcc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        ext_rst_pin_low,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Supplies, detectors and pins
  input  wire logic        porDetect,
  input  wire logic        borDetect,
  input  wire logic        regulatorsReady,
  input  wire logic        fastOscReady,
  input  wire logic        extRstPinLow,
  input  wire logic [4:0]  wakePin,
  input  wire logic        radioTimer1,
  input  wire logic        radioTimer2,
  // Processor and debugger
  input  wire logic        watchdogReset,
  input  wire logic        sysRestartRequest,
  input  wire logic        lockup,
  input  wire logic        debuggerConnected,
  // Reset outputs
  output logic             powerOnReset,
  output logic             coreReset,
  output logic             borEnable,
  // Clock control outputs
  output logic [15:0]      periphClkEn,
  output logic             cpuClkEn,
  output logic             ramClkEn,
  output logic             sysClkFromXtal,
  output logic             fastOscEnable,
  output logic             tree32Mode,
  output logic             sleepActive,
  output logic             standbyActive
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [11:0] asyncIn;
  logic [11:0] syncOut;
  assign asyncIn = {radioTimer2, radioTimer1, wakePin, fastOscReady,
                    regulatorsReady, extRstPinLow, borDetect, porDetect};

  for (genvar i = 0; i < 12; i++) begin : g_sync
    logic meta;
    logic sync;
    always_ff @(posedge clk) begin
      if (!ext_rst_pin_low) begin
        meta <= 1'b0;
        sync <= 1'b0;
      end else begin
        meta <= asyncIn[i];
        sync <= meta;
      end
    end
    assign syncOut[i] = sync;
  end

  logic       porSync;
  logic       borSync;
  logic       pinHighSync;
  logic       regOkSync;
  logic       oscOkSync;
  logic [4:0] pinSync;
  logic       tmr1Sync;
  logic       tmr2Sync;
  assign porSync     = syncOut[0];
  assign borSync     = syncOut[1];
  assign pinHighSync = syncOut[2];
  assign regOkSync   = syncOut[3];
  assign oscOkSync   = syncOut[4];
  assign pinSync     = syncOut[9:5];
  assign tmr1Sync    = syncOut[10];
  assign tmr2Sync    = syncOut[11];

  // ----------------------------------------------------------------
  // Power-on reset
  // ----------------------------------------------------------------
  logic borHit;
  logic porHit;
  logic next_por;
  assign borHit = borSync & borEnable;
  assign porHit = porSync | ~pinHighSync | ~regOkSync | ~oscOkSync;
  assign next_por = borHit | porHit;

  // Debug logic sees only this reset, never the core reset.
  always_ff @(posedge clk) begin
    if (!ext_rst_pin_low) powerOnReset <= 1'b1;
    else powerOnReset <= next_por;
  end

  // ----------------------------------------------------------------
  // Register state and AXI holding registers
  // ----------------------------------------------------------------
  logic [4:0]  wakeLevel;
  logic [4:0]  wakeEnable;
  logic        xtalSel;
  logic [3:1]  sysCause;
  logic [10:0] radioCause;
  logic        awHeld;
  logic        wHeld;
  logic [7:0]  awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        wrDo;
  assign wrDo = awHeld & wHeld & ~s_axi_bvalid;

  function automatic logic isMapped(input logic [7:0] a);
    return a[7:2] inside {OFS_WAKE_LEVEL[7:2], OFS_WAKE_EN[7:2], OFS_XTAL_CTRL[7:2],
                          OFS_CLK_EN[7:2], OFS_SYS_CAUSE[7:2], OFS_RAD_CAUSE[7:2],
                          OFS_PWR_CTRL[7:2]};
  endfunction : isMapped

  // Reserved bits and the request bits of the power control word read as zero.
  function automatic logic [31:0] regRead(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    unique case ({a[7:2], 2'b00})
      OFS_WAKE_LEVEL: v[4:0] = wakeLevel;
      OFS_WAKE_EN:    v[4:0] = wakeEnable;
      OFS_XTAL_CTRL:  v[0] = xtalSel;
      OFS_CLK_EN:     v[15:0] = periphClkEn;
      OFS_SYS_CAUSE:  v[3:1] = sysCause;
      OFS_RAD_CAUSE:  v[10:0] = radioCause;
      OFS_PWR_CTRL:   v[1:0] = {sysClkFromXtal, borEnable};
      default:        v = 32'h0;
    endcase
    return v;
  endfunction : regRead

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  logic [31:0] wrMerged;
  logic [31:0] wrOld;
  logic [4:0]  next_wakeLevel;
  logic [4:0]  next_wakeEnable;
  logic        next_xtalSel;
  logic [15:0] next_clkEn;
  logic        next_borEn;
  logic        next_srcXtal;
  logic        sleepReq;
  logic        standbyReq;

  always_comb begin
    wrOld = regRead(awAddr);
    for (int b = 0; b < 4; b++) begin
      wrMerged[8*b +: 8] = wStrb[b] ? wData[8*b +: 8] : wrOld[8*b +: 8];
    end
    next_wakeLevel  = wakeLevel;
    next_wakeEnable = wakeEnable;
    next_xtalSel    = xtalSel;
    next_clkEn      = periphClkEn;
    next_borEn      = borEnable;
    next_srcXtal    = sysClkFromXtal;
    sleepReq        = 1'b0;
    standbyReq      = 1'b0;
    if (powerOnReset) begin
      next_wakeLevel  = WAKE_LEVEL_RST;
      next_wakeEnable = WAKE_EN_RST;
      next_xtalSel    = XTAL_SEL_RST;
      next_clkEn      = CLK_EN_RST;
      next_borEn      = BOR_EN_RST;
      next_srcXtal    = 1'b0;
    end else if (wrDo) begin
      unique case ({awAddr[7:2], 2'b00})
        OFS_WAKE_LEVEL: next_wakeLevel = wrMerged[4:0];
        OFS_WAKE_EN:    next_wakeEnable = wrMerged[4:0];
        OFS_XTAL_CTRL:  next_xtalSel = wrMerged[0];
        OFS_CLK_EN:     next_clkEn = wrMerged[15:0];
        OFS_PWR_CTRL: begin
          next_borEn   = wrMerged[PC_BOR_EN];
          next_srcXtal = wrMerged[PC_SRC_XTAL];
          sleepReq     = wrMerged[PC_SLEEP];
          standbyReq   = wrMerged[PC_STANDBY];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!ext_rst_pin_low) begin
      wakeLevel      <= WAKE_LEVEL_RST;
      wakeEnable     <= WAKE_EN_RST;
      xtalSel        <= XTAL_SEL_RST;
      periphClkEn    <= CLK_EN_RST;
      borEnable      <= BOR_EN_RST;
      sysClkFromXtal <= 1'b0;
    end else begin
      wakeLevel      <= next_wakeLevel;
      wakeEnable     <= next_wakeEnable;
      xtalSel        <= next_xtalSel;
      periphClkEn    <= next_clkEn;
      borEnable      <= next_borEn;
      sysClkFromXtal <= next_srcXtal;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write and read channels
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!ext_rst_pin_low) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= 8'h00;
      wData         <= 32'h0;
      wStrb         <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr        <= s_axi_awaddr;
        awHeld        <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
        wHeld        <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wrDo) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= isMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!ext_rst_pin_low) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= regRead(s_axi_araddr);
      s_axi_rresp   <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Low-power state and wake detection
  // ----------------------------------------------------------------
  rwcc_pwr_e  pwrState;
  rwcc_pwr_e  next_pwrState;
  logic [4:0] pinWake;
  logic       timerWake;
  logic       wakeEvent;

  for (genvar p = 0; p < 5; p++) begin : g_wake
    assign pinWake[p] = wakeEnable[p] & (pinSync[p] == wakeLevel[p]);
  end
  assign timerWake = (pwrState == PS_SLEEP) & (tmr1Sync | tmr2Sync);

  always_comb begin
    next_pwrState = pwrState;
    unique case (pwrState)
      PS_RUN: begin
        if (sleepReq) next_pwrState = PS_SLEEP;
        else if (standbyReq) next_pwrState = PS_STANDBY;
      end
      PS_SLEEP:   if (|pinWake || timerWake) next_pwrState = PS_RUN;
      PS_STANDBY: if (|pinWake) next_pwrState = PS_RUN;
    endcase
    if (powerOnReset) next_pwrState = PS_RUN;
  end
  assign wakeEvent = (pwrState != PS_RUN) & (next_pwrState == PS_RUN) & ~powerOnReset;

  always_ff @(posedge clk) begin
    if (!ext_rst_pin_low) pwrState <= PS_RUN;
    else pwrState <= next_pwrState;
  end

  // ----------------------------------------------------------------
  // Core reset pulse
  // ----------------------------------------------------------------
  logic [3:1] sysHit;
  logic       coreTrigger;
  logic [3:0] coreCnt;
  logic [3:0] next_coreCnt;
  assign sysHit[SC_SYSREQ] = sysRestartRequest;
  assign sysHit[SC_WDG]    = watchdogReset;
  assign sysHit[SC_LOCKUP] = lockup & ~debuggerConnected;
  assign coreTrigger = wakeEvent | (|sysHit) | powerOnReset;

  always_comb begin
    if (coreTrigger) next_coreCnt = CORE_RST_CNT;
    else if (coreCnt != 4'h0) next_coreCnt = coreCnt - 4'h1;
    else next_coreCnt = 4'h0;
  end

  // The debug reset is not driven from here, so the debugger stays attached.
  always_ff @(posedge clk) begin
    if (!ext_rst_pin_low) begin
      coreCnt   <= CORE_RST_CNT;
      coreReset <= 1'b1;
    end else begin
      coreCnt   <= next_coreCnt;
      coreReset <= (next_coreCnt != 4'h0);
    end
  end

  // ----------------------------------------------------------------
  // Cause records
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!ext_rst_pin_low || powerOnReset) sysCause <= 3'h0;
    else if (|sysHit && !coreReset) sysCause <= sysHit;
    else if (|sysHit) sysCause <= sysCause | sysHit;
    else if (wakeEvent) sysCause <= 3'h0;
  end

  logic [10:0] wakeBits;
  logic [10:0] porBits;
  always_comb begin
    wakeBits = 11'h0;
    wakeBits[RC_PIN0 +: 5] = pinWake;
    wakeBits[RC_TMR1] = timerWake & tmr1Sync;
    wakeBits[RC_TMR2] = timerWake & tmr2Sync;
    porBits = 11'h0;
    porBits[RC_BOR] = borHit;
    porBits[RC_POR] = porHit;
  end

  always_ff @(posedge clk) begin
    if (!ext_rst_pin_low) radioCause <= RAD_CAUSE_RST;
    else if (next_por && !powerOnReset) radioCause <= porBits;
    else if (powerOnReset) radioCause <= radioCause | porBits;
    else if (wakeEvent) radioCause <= wakeBits;
  end

  // ----------------------------------------------------------------
  // Clock control outputs
  // ----------------------------------------------------------------
  logic next_cpuClk;
  assign next_cpuClk = (next_pwrState == PS_RUN);

  always_ff @(posedge clk) begin
    if (!ext_rst_pin_low) begin
      cpuClkEn      <= 1'b1;
      ramClkEn      <= 1'b1;
      fastOscEnable <= 1'b1;
      tree32Mode    <= 1'b0;
      sleepActive   <= 1'b0;
      standbyActive <= 1'b0;
    end else begin
      cpuClkEn      <= next_cpuClk;
      ramClkEn      <= next_cpuClk | next_clkEn[CK_SPI] | next_clkEn[CK_RADIO_CTRL]
                       | next_clkEn[CK_RADIO_GEN];
      fastOscEnable <= ~next_srcXtal;
      tree32Mode    <= next_srcXtal & next_xtalSel;
      sleepActive   <= (next_pwrState == PS_SLEEP);
      standbyActive <= (next_pwrState == PS_STANDBY);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!ext_rst_pin_low);

  a_wake_en_reset: assert property ($rose(ext_rst_pin_low) |-> wakeEnable == WAKE_EN_RST)
    else $error("wake enable not at reset value");
  a_xtal_reset: assert property ($rose(ext_rst_pin_low) |-> !xtalSel && !tree32Mode)
    else $error("crystal select not zero after reset");
  a_tree_mode: assert property (tree32Mode == (xtalSel && sysClkFromXtal))
    else $error("clock tree mode mismatch");
  a_clk_reset: assert property ($rose(ext_rst_pin_low) |-> periphClkEn == CLK_EN_RST)
    else $error("clock enables not at reset value");
  a_cpu_sleep: assert property (pwrState != PS_RUN |-> !cpuClkEn)
    else $error("processor clock running in low power");
  a_ram_gate: assert property (ramClkEn == (cpuClkEn || periphClkEn[CK_SPI]
      || periphClkEn[CK_RADIO_CTRL] || periphClkEn[CK_RADIO_GEN]))
    else $error("RAM clock gate mismatch");
  a_wake_reset: assert property (wakeEvent |=> coreReset [*8] ##1 1)
    else $error("wake did not give full core reset");
  a_sys_reset: assert property (sysRestartRequest && !powerOnReset
      |=> coreReset && sysCause[SC_SYSREQ])
    else $error("restart request not recorded");
  a_lockup_dbg: assert property (lockup && debuggerConnected && !watchdogReset
      && !sysRestartRequest && !wakeEvent && !powerOnReset && !coreReset
      |=> !coreReset)
    else $error("lockup reset with debugger attached");
  a_debug_por: assert property ($rose(powerOnReset) |-> $past(next_por))
    else $error("debug reset without power-on cause");
  a_cause_hold: assert property (!coreTrigger && !next_por |=> $stable(sysCause)
      && $stable(radioCause))
    else $error("cause record changed without reset event");

  c_pin_wake: cover property (pwrState == PS_STANDBY ##1 wakeEvent);
  c_timer_wake: cover property (timerWake && wakeEvent);
  c_watchdog: cover property (watchdogReset && !coreReset);
  c_clk_write: cover property (wrDo && awAddr == OFS_CLK_EN);

endmodule : rwcc_reset_wake_clock_control
`default_nettype wire

// ==== bench/rwcc_supply_model.sv ====
// Purpose: Supply, detector and reset pin model for the control block.
// Assumes: One clock; a pin request restarts the pin-low sequence.
// Notes:   LIM cycles of pin low cover the minimum reset pulse.
`default_nettype none
module rwcc_supply_model #(
  parameter int unsigned LIM = 3750
) (
  // Clock and requests
  input  wire logic clk,
  input  wire logic pinReq,
  input  wire logic borReq,
  // Supply side
  output logic      porDetect,
  output logic      borDetect,
  output logic      regulatorsReady,
  output logic      fastOscReady,
  output logic      extRstPinLow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt = 16'h0;
  always_ff @(posedge clk) begin
    if (pinReq) begin
      cnt <= 16'h0;
    end else if (cnt != 16'(LIM)) begin
      cnt <= cnt + 16'h1;
    end
  end
  // The pin is held low until the supplies have long been good.
  assign extRstPinLow    = (cnt == 16'(LIM));
  assign porDetect       = (cnt < 16'(LIM / 4));
  assign regulatorsReady = (cnt > 16'(LIM / 2));
  assign fastOscReady    = regulatorsReady;
  assign borDetect       = borReq;
endmodule : rwcc_supply_model
`default_nettype wire

// ==== bench/rwcc_reset_wake_clock_control_tb.sv ====
// Purpose: Self-checking bench for the reset, wake and clock control block.
// Assumes: Registered AXI answers; supplies come from the supply model.
// Notes:   Random values come from a fixed seed.
`default_nettype none
module rwcc_reset_wake_clock_control_tb;
  import rwcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0, ext_rst_pin_low = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, lastResp;
  logic        porDetect, borDetect, regulatorsReady, fastOscReady, extRstPinLow;
  logic [4:0]  wakePin = 5'h0;
  logic        radioTimer1 = 1'h0, radioTimer2 = 1'h0, watchdogReset = 1'h0;
  logic        sysRestartRequest = 1'h0, lockup = 1'h0, debuggerConnected = 1'h0;
  logic        pinReq = 1'h0, borReq = 1'h0;
  logic        powerOnReset, coreReset, borEnable, cpuClkEn, ramClkEn, sysClkFromXtal;
  logic        fastOscEnable, tree32Mode, sleepActive, standbyActive;
  logic [15:0] periphClkEn;
  int          mismatches = 0, n_compared = 0, cycles = 0;
  rwcc_reset_wake_clock_control rwcc_reset_wake_clock_control_i (.clk, .ext_rst_pin_low,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .porDetect,
    .borDetect, .regulatorsReady, .fastOscReady, .extRstPinLow, .wakePin, .radioTimer1,
    .radioTimer2, .watchdogReset, .sysRestartRequest, .lockup, .debuggerConnected,
    .powerOnReset, .coreReset, .borEnable, .periphClkEn, .cpuClkEn, .ramClkEn,
    .sysClkFromXtal, .fastOscEnable, .tree32Mode, .sleepActive, .standbyActive);
  rwcc_supply_model rwcc_supply_model_i (.clk, .pinReq, .borReq, .porDetect, .borDetect,
    .regulatorsReady, .fastOscReady, .extRstPinLow);
  // ----------------------------------------------------------------
  // Clock, timeout and tasks
  // ----------------------------------------------------------------
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ga, gw, b;
    ga = 1'h0;
    gw = 1'h0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      @(negedge clk);
      ga = ga | s_axi_awready;
      gw = gw | s_axi_wready;
      @(posedge clk);
      if (ga) s_axi_awvalid <= 1'h0;
      if (gw) s_axi_wvalid <= 1'h0;
    end while (!(ga && gw));
    do begin
      @(negedge clk);
      b = s_axi_bvalid;
      lastResp = s_axi_bresp;
      @(posedge clk);
    end while (!b);
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic g;
    logic [31:0] d;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(negedge clk);
      g = s_axi_arready;
      @(posedge clk);
    end while (!g);
    s_axi_arvalid <= 1'h0;
    do begin
      @(negedge clk);
      g = s_axi_rvalid;
      d = s_axi_rdata;
      lastResp = s_axi_rresp;
      @(posedge clk);
    end while (!g);
    s_axi_rready <= 1'h0;
    chk(d, e);
  endtask : rchk
  task automatic settle();
    do @(negedge clk); while (powerOnReset !== 1'h0 || coreReset !== 1'h0);
  endtask : settle
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v;
    logic        stby;
    v = $urandom(32'h69f6);
    repeat (5) @(posedge clk);
    ext_rst_pin_low <= 1'h1;
    settle();
    rchk(OFS_WAKE_LEVEL, 32'h0);
    rchk(OFS_WAKE_EN, 32'h7);
    rchk(OFS_XTAL_CTRL, 32'h0);
    rchk(OFS_CLK_EN, 32'h7fff);
    rchk(OFS_RAD_CAUSE, 32'h4);
    rchk(OFS_SYS_CAUSE, 32'h0);
    rchk(OFS_PWR_CTRL, 32'h1);
    chk({borEnable, fastOscEnable, sysClkFromXtal}, 3'h6);
    rchk(8'h20, 32'h0);
    chk(lastResp, RESP_SLVERR);
    repeat (4) begin
      v = $urandom & 32'h1f;
      wr(OFS_WAKE_EN, v);
      rchk(OFS_WAKE_EN, v);
      wr(OFS_WAKE_LEVEL, ~v & 32'h1f);
      rchk(OFS_WAKE_LEVEL, ~v & 32'h1f);
    end
    s_axi_wstrb <= 4'h2;
    wr(OFS_WAKE_EN, 32'h0);
    s_axi_wstrb <= 4'hf;
    rchk(OFS_WAKE_EN, v);
    wr(8'h24, 32'h1);
    chk(lastResp, RESP_SLVERR);
    wr(OFS_SYS_CAUSE, 32'he);
    rchk(OFS_SYS_CAUSE, 32'h0);
    wr(OFS_XTAL_CTRL, 32'h1);
    wr(OFS_PWR_CTRL, 32'h3);
    repeat (2) @(negedge clk);
    chk({tree32Mode, fastOscEnable, sysClkFromXtal}, 3'h5);
    wr(OFS_XTAL_CTRL, 32'h0);
    repeat (2) @(negedge clk);
    chk(tree32Mode, 1'h0);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      debuggerConnected <= (k == 3);
      sysRestartRequest <= (k == 0);
      watchdogReset     <= (k == 1);
      lockup            <= (k >= 2);
      @(posedge clk);
      {sysRestartRequest, watchdogReset, lockup} <= 3'h0;
      @(negedge clk);
      chk({coreReset, powerOnReset}, {k < 3, 1'h0});
      settle();
      rchk(OFS_SYS_CAUSE, (k < 3) ? (32'h2 << k) : 32'h8);
    end
    for (int k = 0; k < 7; k++) begin
      v = $urandom & 32'hffff;
      if (k % 2 == 1) v = v & ~32'h106;
      wr(OFS_CLK_EN, v);
      wr(OFS_WAKE_EN, (k < 5) ? (32'h1 << k) : 32'h0);
      wr(OFS_WAKE_LEVEL, 32'h1f);
      stby = (k % 2 == 1) && (k < 5);
      wr(OFS_PWR_CTRL, stby ? 32'h9 : 32'h5);
      repeat (2) @(negedge clk);
      chk(periphClkEn, v[15:0]);
      chk({sleepActive, standbyActive, cpuClkEn}, {!stby, stby, 1'h0});
      chk(ramClkEn, |(v & 32'h106));
      @(posedge clk);
      if (k < 5) wakePin[k] <= 1'h1;
      else if (k == 5) radioTimer1 <= 1'h1;
      else radioTimer2 <= 1'h1;
      do @(negedge clk); while (coreReset !== 1'h1);
      chk({sleepActive, standbyActive, cpuClkEn}, 3'h1);
      @(posedge clk);
      {wakePin, radioTimer1, radioTimer2} <= 7'h0;
      settle();
      rchk(OFS_SYS_CAUSE, 32'h0);
      rchk(OFS_RAD_CAUSE, (k < 5) ? (32'h8 << k) : (k == 5) ? 32'h100 : 32'h400);
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      borReq <= (i == 0);
      pinReq <= (i == 1);
      @(posedge clk);
      pinReq <= 1'h0;
      repeat (6) @(negedge clk);
      chk(powerOnReset, 1'h1);
      @(posedge clk);
      borReq <= 1'h0;
      settle();
      rchk(OFS_WAKE_EN, 32'h7);
      rchk(OFS_RAD_CAUSE, (i == 0) ? 32'h2 : 32'h4);
    end
    complete_run();
  end
endmodule : rwcc_reset_wake_clock_control_tb
`default_nettype wire
